// ---- core_model.sv ----
`timescale 1ns/100ps
// Core side: every request is one strobe cycle set and cleared on rising edges
module core_model
(
  input wire logic clk,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output pointer_pkg::byte_t sfr_wdata,
  output logic external_data_space_move,
  output logic jump_req,
  output pointer_pkg::byte_t jump_acc
);
  // Idle values from time zero
  initial
  begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    external_data_space_move = 1'b0;
    jump_req = 1'b0;
    jump_acc = 8'h00;
  end
  // Register access; released data shows its inverse
  task automatic acc(input logic w, input logic [7:0] a, input pointer_pkg::byte_t d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= w;
    sfr_rd <= ~w;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    sfr_wdata <= ~d;
  endtask
  // Move or indirect jump pulse
  task automatic pulse(input logic j, input pointer_pkg::byte_t a);
    @(posedge clk);
    external_data_space_move <= ~j;
    jump_req <= j;
    jump_acc <= a;
    @(posedge clk);
    external_data_space_move <= 1'b0;
    jump_req <= 1'b0;
    jump_acc <= ~a;
  endtask
endmodule

// ---- dual_data_pointer_unit.sv ----
// Function
// - External-data address comes from chosen pointer
// - Two pointers; 82h/83h reach only active one
// - Select bit 0 picks first or second
// - Reset clears select; behaves as single pointer
// - Unselected pointer holds and stays hidden
// - Toggle bit 6 swaps selection per move
// - Control at 85h, reset 00h, reserved bits zero
// - Each pointer may auto step per transfer
// - Indirect jump targets accumulator plus pointer
// - Mode field: 00 hold, 10 inc, 11 dec
// - Stepping touches only the selected pointer
// - Only external-data moves trigger stepping
`timescale 1ns/100ps
`include "pointer_defines.svh"

module dual_data_pointer_unit
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire pointer_pkg::byte_t sfr_wdata,
  input wire logic external_data_space_move,
  input wire logic jump_req,
  input wire pointer_pkg::byte_t jump_acc,
  output pointer_pkg::byte_t sfr_rdata_q,
  output pointer_pkg::ptr_t external_data_space_addr_q,
  output pointer_pkg::ptr_t jump_target_q,
  output logic jump_valid_q
);

  // Background pointers and their next values
  pointer_pkg::ptr_t first_ptr_q;
  pointer_pkg::ptr_t first_ptr_d;
  pointer_pkg::ptr_t second_ptr_q;
  pointer_pkg::ptr_t second_ptr_d;
  // Stepped candidates from the stepper instances
  pointer_pkg::ptr_t first_step;
  pointer_pkg::ptr_t second_step;
  // Control register live bits
  logic sel_q;
  logic sel_d;
  logic toggle_q;
  logic toggle_d;
  // Mode register, two fields of two bits
  logic [3:0] mode_q;
  logic [3:0] mode_d;
  // Pointer currently acting as the active pointer
  pointer_pkg::ptr_t active_ptr;
  // Write strobes to the pointer bytes
  logic ptr_byte_wr;

  // Picks the pointer that the select bit names
  function automatic pointer_pkg::ptr_t pick(input logic sel, input pointer_pkg::ptr_t p0,
                                             input pointer_pkg::ptr_t p1);
    pick = sel ? p1 : p0;
  endfunction

  // Active pointer as seen by the core
  assign active_ptr = pick(sel_q, first_ptr_q, second_ptr_q);
  // Any write to either pointer byte address
  assign ptr_byte_wr = sfr_wr && (sfr_addr == `PTR_LOW_ADDR || sfr_addr == `PTR_HIGH_ADDR);

  // Stepper for the first pointer
  pointer_stepper u_first_step
  (
    .cur(first_ptr_q),
    .mode(mode_q[`MODE_FIRST_LSB +: 2]),
    .nxt(first_step)
  );

  // Stepper for the second pointer
  pointer_stepper u_second_step
  (
    .cur(second_ptr_q),
    .mode(mode_q[`MODE_SECOND_LSB +: 2]),
    .nxt(second_step)
  );

  // Next state: moves step and toggle, register writes override them
  always_comb
  begin
    first_ptr_d = first_ptr_q;
    second_ptr_d = second_ptr_q;
    sel_d = sel_q;
    toggle_d = toggle_q;
    mode_d = mode_q;
    // A completed external-data move steps only the pointer it used
    if (external_data_space_move)
    begin
      if (sel_q)
      begin
        second_ptr_d = second_step;
      end
      else
      begin
        first_ptr_d = first_step;
      end
      // Swap afterwards so the next move uses the other pointer
      if (toggle_q)
      begin
        sel_d = ~sel_q;
      end
    end
    // Register writes reach only the active pointer
    if (sfr_wr)
    begin
      case (sfr_addr)
        `PTR_LOW_ADDR:
        begin
          if (sel_q)
          begin
            second_ptr_d[7:0] = sfr_wdata;
          end
          else
          begin
            first_ptr_d[7:0] = sfr_wdata;
          end
        end
        `PTR_HIGH_ADDR:
        begin
          if (sel_q)
          begin
            second_ptr_d[15:8] = sfr_wdata;
          end
          else
          begin
            first_ptr_d[15:8] = sfr_wdata;
          end
        end
        `CTRL_ADDR:
        begin
          // Reserved bits are dropped
          sel_d = sfr_wdata[`CTRL_SEL_BIT];
          toggle_d = sfr_wdata[`CTRL_TOGGLE_BIT];
        end
        `MODE_ADDR:
        begin
          mode_d = sfr_wdata[3:0];
        end
        default:
        begin
          // Other addresses belong elsewhere
        end
      endcase
    end
  end

  // Background pointer storage
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      first_ptr_q <= `PTR_RESET;
      second_ptr_q <= `PTR_RESET;
    end
    else
    begin
      first_ptr_q <= first_ptr_d;
      second_ptr_q <= second_ptr_d;
    end
  end

  // Control and mode registers; reset selects the first pointer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // Both live bits take their reset value from the control reset byte
      sel_q <= 1'(`CTRL_RESET >> `CTRL_SEL_BIT);
      toggle_q <= 1'(`CTRL_RESET >> `CTRL_TOGGLE_BIT);
      mode_q <= `MODE_RESET;
    end
    else
    begin
      sel_q <= sel_d;
      toggle_q <= toggle_d;
      mode_q <= mode_d;
    end
  end

  // External-data address register, follows the next active pointer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      external_data_space_addr_q <= `PTR_RESET;
    end
    else
    begin
      external_data_space_addr_q <= pick(sel_d, first_ptr_d, second_ptr_d);
    end
  end

  // Read data, answered one cycle after the read strobe
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sfr_rdata_q <= 8'h00;
    end
    else if (sfr_rd)
    begin
      case (sfr_addr)
        `PTR_LOW_ADDR: sfr_rdata_q <= active_ptr[7:0];
        `PTR_HIGH_ADDR: sfr_rdata_q <= active_ptr[15:8];
        `CTRL_ADDR: sfr_rdata_q <= {1'b0, toggle_q, 5'h00, sel_q};
        `MODE_ADDR: sfr_rdata_q <= {4'h0, mode_q};
        default: sfr_rdata_q <= 8'h00;
      endcase
    end
  end

  // Indirect jump target: accumulator plus active pointer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      jump_target_q <= `PTR_RESET;
      jump_valid_q <= 1'b0;
    end
    else
    begin
      jump_valid_q <= jump_req;
      if (jump_req)
      begin
        jump_target_q <= active_ptr + {8'h00, jump_acc};
      end
    end
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Address output always shows the selected pointer
  external_data_space_addr_sel_a: assert property (external_data_space_addr_q == pick(sel_q, first_ptr_q, second_ptr_q))
    else $error("external-data address differs from active pointer");

  // Low byte read returns the active pointer
  low_byte_read_a: assert property (sfr_rd && sfr_addr == `PTR_LOW_ADDR |=> sfr_rdata_q == $past(active_ptr[7:0]))
    else $error("low byte read does not match active pointer");

  // Hidden second pointer never changes
  hidden_second_a: assert property (!sel_q |=> second_ptr_q == $past(second_ptr_q))
    else $error("unselected second pointer changed");

  // Hidden first pointer never changes
  hidden_first_a: assert property (sel_q |=> first_ptr_q == $past(first_ptr_q))
    else $error("unselected first pointer changed");

  // Control read shows reserved bits as zero
  ctrl_reserved_a: assert property (sfr_rd && sfr_addr == `CTRL_ADDR |=> (sfr_rdata_q & ~`CTRL_LIVE_MASK) == 8'h00)
    else $error("reserved control bits read nonzero");

  // Toggle swaps selection on each move
  toggle_swap_a: assert property (external_data_space_move && toggle_q && !(sfr_wr && sfr_addr == `CTRL_ADDR)
    |=> sel_q != $past(sel_q))
    else $error("selection not swapped after move");

  // First pointer increments on a move in increment mode
  step_inc_a: assert property (external_data_space_move && !sel_q && mode_q[1:0] == `STEP_INC && !ptr_byte_wr
    |=> first_ptr_q == $past(first_ptr_q) + 16'h0001)
    else $error("first pointer not incremented after move");

  // Second pointer decrement mode
  step_dec_a: assert property (external_data_space_move && sel_q && mode_q[3:2] == `STEP_DEC && !ptr_byte_wr
    |=> second_ptr_q == $past(second_ptr_q) - 16'h0001)
    else $error("second pointer not decremented after move");

  // Without a move or write both pointers hold
  no_move_hold_a: assert property (!external_data_space_move && !sfr_wr
    |=> first_ptr_q == $past(first_ptr_q) && second_ptr_q == $past(second_ptr_q))
    else $error("pointer changed without a move");

  // Jump target is sum of accumulator and pointer
  jump_sum_a: assert property (jump_req |=> jump_valid_q && jump_target_q == $past(active_ptr)
    + {8'h00, $past(jump_acc)})
    else $error("jump target wrong");

endmodule

// ---- pointer_defines.svh ----
`ifndef POINTER_DEFINES_SVH
`define POINTER_DEFINES_SVH

// Special-function addresses seen by the core
`define PTR_LOW_ADDR 8'h82
`define PTR_HIGH_ADDR 8'h83
`define CTRL_ADDR 8'h85
`define MODE_ADDR 8'h86

// Control register fields and reset value
`define CTRL_SEL_BIT 0
`define CTRL_TOGGLE_BIT 6
`define CTRL_RESET 8'h00
`define CTRL_LIVE_MASK 8'h41

// Mode register fields and reset value
`define MODE_FIRST_LSB 0
`define MODE_SECOND_LSB 2
`define MODE_RESET 4'h0

// Step mode codes
`define STEP_HOLD 2'h0
`define STEP_RSVD 2'h1
`define STEP_INC 2'h2
`define STEP_DEC 2'h3

// Pointer reset value
`define PTR_RESET 16'h0000

`endif

// ---- pointer_pkg.sv ----
package pointer_pkg;

  // One 16-bit external-data address
  typedef logic [15:0] ptr_t;

  // One special-function register byte
  typedef logic [7:0] byte_t;

  // Two-bit automatic step mode
  typedef logic [1:0] step_mode_t;

endpackage

// ---- pointer_stepper.sv ----
`timescale 1ns/100ps
`include "pointer_defines.svh"

// Works out the pointer value after one external-data move
module pointer_stepper
(
  input wire pointer_pkg::ptr_t cur,
  input wire pointer_pkg::step_mode_t mode,
  output pointer_pkg::ptr_t nxt
);

  // Increment, decrement or hold; the reserved code holds
  always_comb
  begin
    unique case (mode)
      `STEP_INC: nxt = cur + 16'h0001;
      `STEP_DEC: nxt = cur - 16'h0001;
      `STEP_HOLD: nxt = cur;
      `STEP_RSVD: nxt = cur;
    endcase
  end

endmodule

// ---- testbench.sv ----
`timescale 1ns/100ps
`include "pointer_defines.svh"
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic sfr_rd;
  logic external_data_space_move;
  logic jump_req;
  logic jump_valid_q;
  pointer_pkg::byte_t sfr_wdata;
  pointer_pkg::byte_t jump_acc;
  pointer_pkg::byte_t sfr_rdata_q;
  pointer_pkg::ptr_t external_data_space_addr_q;
  pointer_pkg::ptr_t jump_target_q;
  int err_total = 0;
  int n_tests = 0;
  int seed = 32'h3895;
  int cyc = 0;
  // Shadow of both pointers, select, toggle and modes
  pointer_pkg::ptr_t p [2];
  logic sel = 1'b0;
  logic tog = 1'b0;
  logic [3:0] md = 4'h0;
  logic [7:0] ra [4] = '{8'h82, 8'h83, 8'h85, 8'h86};
  logic [31:0] r;
  always #2.5 clk = ~clk;
  core_model u_core (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .external_data_space_move(external_data_space_move), .jump_req(jump_req), .jump_acc(jump_acc));
  dual_data_pointer_unit u_dut (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .external_data_space_move(external_data_space_move), .jump_req(jump_req),
    .jump_acc(jump_acc), .sfr_rdata_q(sfr_rdata_q), .external_data_space_addr_q(external_data_space_addr_q),
    .jump_target_q(jump_target_q), .jump_valid_q(jump_valid_q));
  // Verdict and end of run
  task automatic end_of_test;
    if (err_total == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Pointer after one move in the given mode
  function automatic pointer_pkg::ptr_t step(input pointer_pkg::ptr_t v, input logic [1:0] m);
    step = (m == `STEP_INC) ? v + 16'h0001 : (m == `STEP_DEC) ? v - 16'h0001 : v;
  endfunction
  // Expected read data at an address
  function automatic pointer_pkg::byte_t rexp(input logic [7:0] a);
    case (a)
      `PTR_LOW_ADDR: rexp = p[sel][7:0];
      `PTR_HIGH_ADDR: rexp = p[sel][15:8];
      `CTRL_ADDR: rexp = {1'b0, tog, 5'h00, sel};
      `MODE_ADDR: rexp = {4'h0, md};
      default: rexp = 8'h00;
    endcase
  endfunction
  // Read and compare with the shadow
  task automatic rdchk(input logic [7:0] a);
    u_core.acc(1'b0, a, 8'h00);
    #1;
    chk({8'h00, sfr_rdata_q}, {8'h00, rexp(a)});
  endtask
  // Write and follow it in the shadow
  task automatic wrm(input logic [7:0] a, input pointer_pkg::byte_t d);
    u_core.acc(1'b1, a, d);
    if (a == `PTR_LOW_ADDR) p[sel][7:0] = d;
    if (a == `PTR_HIGH_ADDR) p[sel][15:8] = d;
    if (a == `CTRL_ADDR) {tog, sel} = {d[6], d[0]};
    if (a == `MODE_ADDR) md = d[3:0];
  endtask
  // One move: step the used pointer, then toggle
  task automatic move;
    u_core.pulse(1'b0, 8'h00);
    p[sel] = step(p[sel], md[2 * sel +: 2]);
    sel = sel ^ tog;
    @(posedge clk);
    #1;
    chk(external_data_space_addr_q, p[sel]);
  endtask
  // Indirect jump: target is accumulator plus active pointer, no step
  task automatic jump(input pointer_pkg::byte_t a);
    u_core.pulse(1'b1, a);
    #1;
    chk({15'h0000, jump_valid_q}, 16'h0001);
    chk(jump_target_q, p[sel] + {8'h00, a});
    @(posedge clk);
    #1;
    chk({15'h0000, jump_valid_q}, 16'h0000);
    chk(external_data_space_addr_q, p[sel]);
  endtask
  // Cuts a hang short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc > 20000)
    begin
      err_total++;
      end_of_test;
    end
  end
  // Main sequence
  initial
  begin
    p[0] = 16'h0000;
    p[1] = 16'h0000;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk(external_data_space_addr_q, 16'h0000);
    rdchk(8'h85);
    rdchk(8'h86);
    wrm(8'h82, 8'h34);
    wrm(8'h83, 8'h12);
    wrm(8'h85, 8'h01);
    rdchk(8'h82);
    wrm(8'h82, 8'hff);
    wrm(8'h83, 8'hff);
    wrm(8'h85, 8'hff);
    rdchk(8'h85);
    wrm(8'h86, 8'hfb);
    rdchk(8'h86);
    rdchk(8'h84);
    wrm(8'h85, 8'h40);
    rdchk(8'h83);
    wrm(8'h86, 8'h0b);
    repeat (4) move;
    wrm(8'h86, 8'h0e);
    repeat (3) move;
    for (int i = 0; i < 300; i++)
    begin
      r = $random(seed);
      case (r[2:0])
        3'h0: wrm(8'h82, r[15:8]);
        3'h1: wrm(8'h83, r[15:8]);
        3'h2: wrm(8'h85, r[15:8]);
        3'h3: wrm(8'h86, r[15:8]);
        3'h4: jump(r[15:8]);
        3'h5: rdchk(ra[r[9:8]]);
        default: move;
      endcase
    end
    // Mid-run reset returns every register and output to its reset value
    @(posedge clk);
    nrst <= 1'b0;
    #1;
    chk(external_data_space_addr_q, `PTR_RESET);
    chk({8'h00, sfr_rdata_q}, 16'h0000);
    chk(jump_target_q, `PTR_RESET);
    chk({15'h0000, jump_valid_q}, 16'h0000);
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    // Shadow follows the reset
    p[0] = `PTR_RESET;
    p[1] = `PTR_RESET;
    sel = 1'b0;
    tog = 1'b0;
    md = 4'h0;
    rdchk(8'h85);
    rdchk(8'h86);
    rdchk(8'h83);
    // Hold mode after reset: no step and no toggle
    move;
    // Reserved step code on both fields; toggle is off, so the moves use only the first pointer, which holds
    wrm(8'h86, 8'h05);
    repeat (2) move;
    end_of_test;
  end
endmodule
